/* logic/sfmio_cfg.svh */
`ifndef SFMIO_CFG_SVH
`define SFMIO_CFG_SVH

// instruction opcodes
`define SFMIO_OP_READ 8'h03
`define SFMIO_OP_FAST 8'h0B
`define SFMIO_OP_DOUT 8'h3B
`define SFMIO_OP_DIO 8'hBB
`define SFMIO_OP_QOUT 8'h6B
`define SFMIO_OP_QIO 8'hEB
`define SFMIO_OP_PROG 8'h02
`define SFMIO_OP_SERASE 8'h20
`define SFMIO_OP_BERASE 8'hD8
`define SFMIO_OP_CERASE 8'hC7
`define SFMIO_OP_WRSR 8'h01
`define SFMIO_OP_WAKE 8'hAB

// last cycle index of each input phase
`define SFMIO_INSTR_LAST 5'd7
`define SFMIO_ADDR1_LAST 5'd23
`define SFMIO_DUAL_IN_LAST 5'd15
`define SFMIO_QUAD_IN_LAST 5'd7

// latency cycles
`define SFMIO_SINGLE_LAT 4'd8
`define SFMIO_DIO_LAT 4'd4

// timing
`define SFMIO_CLK_NS 10
`define SFMIO_PUW_MIN_NS 1000000
`define SFMIO_PUW_CYCLES \
  ((`SFMIO_PUW_MIN_NS + `SFMIO_CLK_NS - 1) / `SFMIO_CLK_NS)

`endif

/* logic/sfmio_pkg.sv */
package sfmio_pkg;

  typedef enum logic [3:0] {
    SFMIO_IDLE,
    SFMIO_INSTR,
    SFMIO_ADDR1,
    SFMIO_DUAL_IN,
    SFMIO_QUAD_IN,
    SFMIO_LAT,
    SFMIO_OUT1,
    SFMIO_OUT2,
    SFMIO_OUT4,
    SFMIO_SKIP,
    SFMIO_IGNORE
  } sfmio_state_t;

  typedef enum logic [1:0] {
    SFMIO_W1,
    SFMIO_W2,
    SFMIO_W4
  } sfmio_width_t;

endpackage

/* logic/sfmio_sync.sv */
module sfmio_sync #(
  parameter int WIDTH = 7
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  generate
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta_reg[i] <= 1'b0;
          q[i] <= 1'b0;
        end
        else
        begin
          meta_reg[i] <= d[i];
          q[i] <= meta_reg[i];
        end
      end
    end
  endgenerate

endmodule

/* logic/sfmio_phase.sv */
// Overview of operation
// - single output drives serial out, ignores input
// - single output repeats until select rises
// - dual input always goes to latency
// - dual latency neither samples nor drives lines
// - last dual latency leads to dual output
// - dual output two bits until select rises
// - quad input goes to latency or output
// - quad latency length from latency field
// - quad latency lines idle, host releases
// - quad output four bits until select rises
// - quad enable ignores pause, allows quad reads
// - low supply ignores all commands
// - write commands rejected during power-up delay
// - deep sleep accepts only wake command
// - writes need clock count multiple of eight
// - pause low freezes command, lines released
// - instruction captured msb first on rises
// - power-up delay between one and ten ms
`include "sfmio_cfg.svh"

module sfmio_phase #(
  parameter int PUW_CYCLES = `SFMIO_PUW_CYCLES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  input wire logic supply_low,
  input wire logic quad_enable_bit,
  input wire logic [3:0] latency_count_field,
  input wire logic deep_sleep_mode,
  input wire logic [7:0] read_data,
  output logic [23:0] read_addr,
  output logic byte_taken,
  output logic cmd_exec,
  output logic [7:0] exec_opcode,
  output logic wake_cmd,
  output logic write_ready,
  output logic [3:0] phase
);

  logic rst_meta_reg;
  logic rst_n;
  logic [6:0] sync_q;
  logic sck_s;
  logic sel_s;
  logic supply_s;
  logic [3:0] io_s;
  logic sck_d_reg;
  logic sel_d_reg;
  logic pause;
  logic rise_e;
  logic fall_e;
  sfmio_pkg::sfmio_state_t state_reg;
  sfmio_pkg::sfmio_state_t lat_out_reg;
  logic [4:0] cnt_reg;
  logic [3:0] lat_reg;
  logic [7:0] op_reg;
  logic [7:0] opc;
  logic [31:0] in_sh_reg;
  logic write_cmd_reg;
  logic [2:0] pulses_reg;
  logic [7:0] out_sh_reg;
  logic [3:0] bits_left_reg;
  logic [3:0] oe_reg;
  logic [19:0] puw_cnt_reg;
  logic in_done;
  logic [3:0] step;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  sfmio_sync #(.WIDTH(7)) u_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .d({supply_low, ~cs_n, sck, io_in}),
    .q(sync_q)
  );

  assign supply_s = sync_q[6];
  assign sel_s = sync_q[5];
  assign sck_s = sync_q[4];
  assign io_s = sync_q[3:0];

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sck_d_reg <= 1'b0;
      sel_d_reg <= 1'b0;
    end
    else
    begin
      sck_d_reg <= sck_s;
      sel_d_reg <= sel_s;
    end
  end

  // pause pin is io3 only while quad mode is off
  assign pause = !quad_enable_bit && !io_s[3];
  assign rise_e = sck_s && !sck_d_reg && sel_s && !pause;
  assign fall_e = !sck_s && sck_d_reg && sel_s && !pause;
  assign opc = {op_reg[6:0], io_s[0]};

  always_comb
  begin
    in_done = 1'b0;
    case (state_reg)
      sfmio_pkg::SFMIO_ADDR1: in_done = cnt_reg == `SFMIO_ADDR1_LAST;
      sfmio_pkg::SFMIO_DUAL_IN: in_done = cnt_reg == `SFMIO_DUAL_IN_LAST;
      sfmio_pkg::SFMIO_QUAD_IN: in_done = cnt_reg == `SFMIO_QUAD_IN_LAST;
      default: in_done = 1'b0;
    endcase
  end

  // phase sequencing on link clock rising edges
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= sfmio_pkg::SFMIO_IDLE;
      lat_out_reg <= sfmio_pkg::SFMIO_OUT1;
      cnt_reg <= 5'h00;
      lat_reg <= 4'h0;
      op_reg <= 8'h00;
      in_sh_reg <= 32'h0000_0000;
      write_cmd_reg <= 1'b0;
      read_addr <= 24'h00_0000;
      wake_cmd <= 1'b0;
    end
    else
    begin
      wake_cmd <= 1'b0;
      if (!sel_s)
      begin
        state_reg <= sfmio_pkg::SFMIO_IDLE;
        write_cmd_reg <= 1'b0;
      end
      else if (supply_s)
      begin
        state_reg <= sfmio_pkg::SFMIO_IGNORE;
        write_cmd_reg <= 1'b0;
      end
      else if (state_reg == sfmio_pkg::SFMIO_IDLE)
      begin
        state_reg <= sfmio_pkg::SFMIO_INSTR;
        cnt_reg <= 5'h00;
      end
      else if (rise_e)
      begin
        cnt_reg <= cnt_reg + 5'h01;
        case (state_reg)
          sfmio_pkg::SFMIO_INSTR:
          begin
            op_reg <= opc;
            if (cnt_reg == `SFMIO_INSTR_LAST)
            begin
              cnt_reg <= 5'h00;
              lat_reg <= `SFMIO_SINGLE_LAT;
              state_reg <= sfmio_pkg::SFMIO_SKIP;
              if (deep_sleep_mode)
              begin
                if (opc == `SFMIO_OP_WAKE)
                  wake_cmd <= 1'b1;
                else
                  state_reg <= sfmio_pkg::SFMIO_IGNORE;
              end
              else
                case (opc)
                  `SFMIO_OP_READ:
                  begin
                    state_reg <= sfmio_pkg::SFMIO_ADDR1;
                    lat_reg <= 4'h0;
                    lat_out_reg <= sfmio_pkg::SFMIO_OUT1;
                  end
                  `SFMIO_OP_FAST:
                  begin
                    state_reg <= sfmio_pkg::SFMIO_ADDR1;
                    lat_out_reg <= sfmio_pkg::SFMIO_OUT1;
                  end
                  `SFMIO_OP_DOUT:
                  begin
                    state_reg <= sfmio_pkg::SFMIO_ADDR1;
                    lat_out_reg <= sfmio_pkg::SFMIO_OUT2;
                  end
                  `SFMIO_OP_QOUT:
                  begin
                    state_reg <= quad_enable_bit ? sfmio_pkg::SFMIO_ADDR1
                      : sfmio_pkg::SFMIO_IGNORE;
                    lat_out_reg <= sfmio_pkg::SFMIO_OUT4;
                  end
                  `SFMIO_OP_DIO:
                  begin
                    state_reg <= sfmio_pkg::SFMIO_DUAL_IN;
                    lat_reg <= `SFMIO_DIO_LAT;
                    lat_out_reg <= sfmio_pkg::SFMIO_OUT2;
                  end
                  `SFMIO_OP_QIO:
                  begin
                    state_reg <= quad_enable_bit ? sfmio_pkg::SFMIO_QUAD_IN
                      : sfmio_pkg::SFMIO_IGNORE;
                    lat_reg <= latency_count_field;
                    lat_out_reg <= sfmio_pkg::SFMIO_OUT4;
                  end
                  `SFMIO_OP_PROG, `SFMIO_OP_SERASE, `SFMIO_OP_BERASE,
                  `SFMIO_OP_CERASE, `SFMIO_OP_WRSR:
                    write_cmd_reg <= 1'b1;
                  default:
                    state_reg <= sfmio_pkg::SFMIO_SKIP;
                endcase
            end
          end
          sfmio_pkg::SFMIO_ADDR1:
            in_sh_reg <= {in_sh_reg[30:0], io_s[0]};
          sfmio_pkg::SFMIO_DUAL_IN:
            in_sh_reg <= {in_sh_reg[29:0], io_s[1:0]};
          sfmio_pkg::SFMIO_QUAD_IN:
            in_sh_reg <= {in_sh_reg[27:0], io_s};
          sfmio_pkg::SFMIO_LAT:
          begin
            // lines neither sampled nor driven here
            if (cnt_reg == {1'b0, lat_reg} - 5'h01)
              state_reg <= lat_out_reg;
          end
          default:
            cnt_reg <= 5'h00; // output phases hold until select rises
        endcase
        if (in_done)
        begin
          cnt_reg <= 5'h00;
          if (state_reg == sfmio_pkg::SFMIO_DUAL_IN)
            read_addr <= {in_sh_reg[29:6]};
          else if (state_reg == sfmio_pkg::SFMIO_QUAD_IN)
            read_addr <= {in_sh_reg[27:4]};
          else
            read_addr <= {in_sh_reg[22:0], io_s[0]};
          if (lat_reg == 4'h0)
            state_reg <= lat_out_reg;
          else
            state_reg <= sfmio_pkg::SFMIO_LAT;
        end
      end
      else if (byte_taken)
        read_addr <= read_addr + 24'h00_0001;
    end
  end

  always_comb
  begin
    case (state_reg)
      sfmio_pkg::SFMIO_OUT2: step = 4'h2;
      sfmio_pkg::SFMIO_OUT4: step = 4'h4;
      default: step = 4'h1;
    endcase
  end

  // output shifting on falling edges, read data taken per byte
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_sh_reg <= 8'h00;
      bits_left_reg <= 4'h0;
      oe_reg <= 4'h0;
      io_out <= 4'h0;
      byte_taken <= 1'b0;
    end
    else
    begin
      byte_taken <= 1'b0;
      if (!sel_s || supply_s)
      begin
        oe_reg <= 4'h0;
        bits_left_reg <= 4'h0;
      end
      else if (fall_e)
      begin
        case (state_reg)
          sfmio_pkg::SFMIO_OUT1, sfmio_pkg::SFMIO_OUT2,
          sfmio_pkg::SFMIO_OUT4:
          begin
            if (bits_left_reg == 4'h0)
            begin
              io_out <= read_data[7:4];
              out_sh_reg <= read_data;
              bits_left_reg <= 4'h8 - step;
              byte_taken <= 1'b1;
            end
            else
            begin
              io_out <= out_sh_reg[7:4];
              bits_left_reg <= bits_left_reg - step;
            end
            if (bits_left_reg == 4'h0)
              out_sh_reg <= read_data << step;
            else
              out_sh_reg <= out_sh_reg << step;
            if (state_reg == sfmio_pkg::SFMIO_OUT1)
            begin
              oe_reg <= 4'h2;
              io_out <= {2'h0, bits_left_reg == 4'h0 ? read_data[7]
                : out_sh_reg[7], 1'b0};
            end
            else if (state_reg == sfmio_pkg::SFMIO_OUT2)
            begin
              oe_reg <= 4'h3;
              io_out <= {2'h0, bits_left_reg == 4'h0 ? read_data[7:6]
                : out_sh_reg[7:6]};
            end
            else
              oe_reg <= 4'hF;
          end
          default:
            oe_reg <= 4'h0;
        endcase
      end
    end
  end

  // held paused command keeps its lines released
  assign io_oe = pause ? 4'h0 : oe_reg;

  // clock pulse count and write execution at end of select
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pulses_reg <= 3'h0;
      cmd_exec <= 1'b0;
      exec_opcode <= 8'h00;
    end
    else
    begin
      cmd_exec <= 1'b0;
      if (rise_e)
        pulses_reg <= pulses_reg + 3'h1;
      if (sel_d_reg && !sel_s)
      begin
        pulses_reg <= 3'h0;
        exec_opcode <= op_reg;
        cmd_exec <= write_cmd_reg && pulses_reg == 3'h0 && write_ready
          && !supply_s;
      end
    end
  end

  // power-up write delay
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      puw_cnt_reg <= 20'h0_0000;
      write_ready <= 1'b0;
    end
    else if (!write_ready)
    begin
      puw_cnt_reg <= puw_cnt_reg + 20'h0_0001;
      if (puw_cnt_reg == 20'(PUW_CYCLES - 1))
        write_ready <= 1'b1;
    end
  end

  assign phase = state_reg;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  property p_lat_quiet;
    state_reg == sfmio_pkg::SFMIO_LAT |-> io_oe == 4'h0;
  endproperty
  a_lat_quiet: assert property (p_lat_quiet)
    else $error("lines driven during latency");

  property p_cs_release;
    $fell(sel_s) |=> io_oe == 4'h0 && state_reg == sfmio_pkg::SFMIO_IDLE;
  endproperty
  a_cs_release: assert property (p_cs_release)
    else $error("lines not released after select rose");

  property p_single_oe;
    state_reg == sfmio_pkg::SFMIO_OUT1 && io_oe != 4'h0 |-> io_oe == 4'h2;
  endproperty
  a_single_oe: assert property (p_single_oe)
    else $error("single output drives wrong lines");

  property p_dual_oe;
    state_reg == sfmio_pkg::SFMIO_OUT2 && io_oe != 4'h0 |-> io_oe == 4'h3;
  endproperty
  a_dual_oe: assert property (p_dual_oe)
    else $error("dual output drives wrong lines");

  property p_quad_gate;
    state_reg == sfmio_pkg::SFMIO_QUAD_IN |-> quad_enable_bit;
  endproperty
  a_quad_gate: assert property (p_quad_gate)
    else $error("quad read while quad mode off");

  property p_pause;
    pause && sel_s |-> io_oe == 4'h0;
  endproperty
  a_pause: assert property (p_pause)
    else $error("lines driven while paused");

  property p_pause_freeze;
    pause && sel_s && !supply_s && state_reg != sfmio_pkg::SFMIO_IDLE
      |=> $stable(cnt_reg) && $stable(bits_left_reg);
  endproperty
  a_pause_freeze: assert property (p_pause_freeze)
    else $error("command advanced while paused");

  property p_exec_gate;
    cmd_exec |-> write_ready && $past(pulses_reg) == 3'h0
      && !$past(supply_s);
  endproperty
  a_exec_gate: assert property (p_exec_gate)
    else $error("write executed without checks");

  property p_puw;
    $rose(write_ready) |-> $past(puw_cnt_reg) == 20'(PUW_CYCLES - 1);
  endproperty
  a_puw: assert property (p_puw)
    else $error("power-up delay wrong length");

  property p_sleep;
    deep_sleep_mode && state_reg == sfmio_pkg::SFMIO_INSTR && rise_e
      && cnt_reg == 5'h07 && opc != 8'hAB
      |=> state_reg == sfmio_pkg::SFMIO_IGNORE || !sel_s;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("command accepted in deep sleep");

  c_quad_out: cover property (state_reg == sfmio_pkg::SFMIO_OUT4
    && byte_taken);
  c_dual_lat: cover property (state_reg == sfmio_pkg::SFMIO_LAT
    ##[1:300] state_reg == sfmio_pkg::SFMIO_OUT2);
  c_exec: cover property (cmd_exec);
  c_wake: cover property (wake_cmd);

endmodule

/* sim/sfmio_host_model.sv */
module sfmio_host_model (
  input wire logic ref_clk,
  input wire logic [3:0] line,
  output logic sck,
  output logic cs_n,
  output logic [3:0] host_out,
  output logic [3:0] host_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic pause_n;
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    host_oe = 4'hC;
    host_out = 4'hC;
    pause_n = 1'b1;
  end
  task start;
    @(posedge ref_clk);
    cs_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
  // sck low before select rises, drives io3 and io2 again only after the device lets go
  task stop;
    @(posedge ref_clk);
    sck <= 1'b0;
    repeat (4) @(posedge ref_clk);
    cs_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    host_oe <= 4'hC;
    host_out <= {pause_n, 3'h4};
    repeat (2) @(posedge ref_clk);
  endtask
  task hold(input logic p);
    @(posedge ref_clk);
    pause_n <= ~p;
    host_out[3] <= ~p;
  endtask
  // one 80 ns clock per bit group, data set while sck low
  task automatic xfer(input int w, input int n, input logic drv,
    input logic [31:0] dout, output logic [31:0] din);
    logic [3:0] m;
    logic [31:0] dd;
    m = (w == 4) ? 4'hF : ((w == 2) ? 4'h3 : 4'h1);
    dd = dout;
    din = 32'h0;
    repeat (n)
    begin
      @(posedge ref_clk);
      sck <= 1'b0;
      host_oe <= ((w == 4) ? 4'h0 : 4'hC) | (drv ? m : 4'h0);
      host_out <= (dd[31:28] >> (4 - w)) |
        ((w == 4) ? 4'h0 : {pause_n, 3'h4});
      dd = dd << w;
      repeat (4) @(posedge ref_clk);
      sck <= 1'b1;
      repeat (3) @(posedge ref_clk);
      din = (din << w) | ((line >> ((w == 1) ? 1 : 0)) & m);
    end
  endtask
endmodule

/* sim/tb_top.sv */
`include "sfmio_cfg.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PUW = 300;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  wire sck;
  wire cs_n;
  wire [3:0] host_out;
  wire [3:0] host_oe;
  wire [3:0] line;
  wire [7:0] read_data;
  logic [3:0] io_out;
  logic [3:0] io_oe;
  logic [3:0] float_pat = 4'h5;
  logic supply_low = 1'b0;
  logic qe = 1'b0;
  logic deep = 1'b0;
  logic [3:0] lat_f = 4'h0;
  logic [23:0] read_addr;
  logic byte_taken;
  logic cmd_exec;
  logic wake_cmd;
  logic write_ready;
  logic [7:0] exec_opcode;
  logic [3:0] phase;
  logic [7:0] last_op = 8'h00;
  int mismatches = 0;
  int checks_done = 0;
  int oe_cnt = 0;
  int exec_cnt = 0;
  int wake_cnt = 0;
  int bt_cnt = 0;
  int cyc = 0;
  int rel_cyc = 0;
  // released lines show a changing pattern
  assign line = (io_oe & io_out) | (~io_oe & host_oe & host_out) |
    (~io_oe & ~host_oe & float_pat);
  assign read_data = read_addr[7:0] ^ 8'h5A;
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    float_pat <= ~float_pat;
    cyc <= cyc + 1;
    if (io_oe != 4'h0)
      oe_cnt <= oe_cnt + 1;
    if (cmd_exec === 1'b1)
    begin
      exec_cnt <= exec_cnt + 1;
      last_op <= exec_opcode;
    end
    if (wake_cmd === 1'b1)
      wake_cnt <= wake_cnt + 1;
    if (byte_taken === 1'b1)
      bt_cnt <= bt_cnt + 1;
    if ((io_oe & host_oe) != 4'h0)
    begin
      $display("MISMATCH %0t: line contention", $time);
      mismatches++;
    end
  end
  sfmio_host_model host (.ref_clk(ref_clk), .line(line), .sck(sck),
    .cs_n(cs_n), .host_out(host_out), .host_oe(host_oe));
  sfmio_phase #(.PUW_CYCLES(PUW)) dut (.ref_clk(ref_clk), .resetn(resetn),
    .sck(sck), .cs_n(cs_n), .io_in(line), .io_out(io_out), .io_oe(io_oe),
    .supply_low(supply_low), .quad_enable_bit(qe),
    .latency_count_field(lat_f), .deep_sleep_mode(deep),
    .read_data(read_data), .read_addr(read_addr), .byte_taken(byte_taken),
    .cmd_exec(cmd_exec), .exec_opcode(exec_opcode), .wake_cmd(wake_cmd),
    .write_ready(write_ready), .phase(phase));
  task automatic check(input logic [31:0] got, input logic [31:0] exp,
    input string what);
    checks_done++;
    if (got !== exp)
    begin
      $display("MISMATCH %0t: %s got %0h exp %0h", $time, what, got, exp);
      mismatches++;
    end
  endtask
  task summarize;
    $display("counts: %0d checks, %0d mismatches", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] op, input int n);
    logic [31:0] d;
    int r;
    r = n - 8;
    host.start();
    host.xfer(1, 8, 1'b1, {op, 24'h0}, d);
    while (r > 0)
    begin
      host.xfer(1, (r > 32) ? 32 : r, 1'b1, 32'h0, d);
      r = r - 32;
    end
    host.stop();
    repeat (6) @(posedge ref_clk);
  endtask
  task automatic read_one(input logic [7:0] op, input int wi, input int ni,
    input int lat, input int wo, input logic [23:0] a);
    logic [31:0] d;
    int c0;
    int b0;
    host.start();
    host.xfer(1, 8, 1'b1, {op, 24'h0}, d);
    host.xfer(wi, ni, 1'b1, {a, 8'h00}, d);
    c0 = oe_cnt;
    b0 = bt_cnt;
    if (lat > 0)
      host.xfer(wo, lat, 1'b0, 32'h0, d);
    check(oe_cnt - c0, 0, "drive in latency");
    host.xfer(wo, 16 / wo, 1'b0, 32'h0, d);
    check(bt_cnt - b0, 2, "bytes loaded");
    check(d[15:0], {a[7:0] ^ 8'h5A, (a[7:0] + 8'h01) ^ 8'h5A},
      "read data");
    host.stop();
    check(io_oe, 4'h0, "release at select high");
    check(phase, sfmio_pkg::SFMIO_IDLE, "idle at select high");
  endtask
  task automatic t_powerup;
    int e0;
    e0 = exec_cnt;
    check(write_ready, 1'b0, "early ready");
    wr(`SFMIO_OP_CERASE, 8);
    check(exec_cnt - e0, 0, "early write");
    while (write_ready !== 1'b1 && cyc < rel_cyc + PUW + 50)
      @(posedge ref_clk);
    check(cyc - rel_cyc >= PUW && cyc - rel_cyc <= PUW + 8, 1,
      "delay length");
    $display("test powerup done");
  endtask
  task automatic t_reads;
    int lv[3] = '{0, 3, 15};
    @(posedge ref_clk);
    qe <= 1'b1;
    read_one(`SFMIO_OP_READ, 1, 24, 0, 1, 24'h1234FF);
    read_one(`SFMIO_OP_FAST, 1, 24, `SFMIO_SINGLE_LAT, 1, 24'h00A0FF);
    read_one(`SFMIO_OP_DOUT, 1, 24, `SFMIO_SINGLE_LAT, 2, 24'h0F0F10);
    read_one(`SFMIO_OP_DIO, 2, 16, `SFMIO_DIO_LAT, 2, 24'hFFFFFF);
    read_one(`SFMIO_OP_QOUT, 1, 24, `SFMIO_SINGLE_LAT, 4, 24'h55AA01);
    for (int i = 0; i < 3; i++)
    begin
      lat_f <= lv[i][3:0];
      read_one(`SFMIO_OP_QIO, 4, 8, lv[i], 4, 24'hABCDEF);
    end
    $display("test reads done");
  endtask
  task automatic t_quad_off;
    logic [31:0] d;
    logic [7:0] ops[2] = '{`SFMIO_OP_QOUT, `SFMIO_OP_QIO};
    int c0;
    @(posedge ref_clk);
    qe <= 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      host.start();
      host.xfer(1, 8, 1'b1, {ops[i], 24'h0}, d);
      c0 = oe_cnt;
      host.xfer(1, 40, 1'b0, 32'h0, d);
      check(oe_cnt - c0, 0, "quad read refused");
      check(phase, sfmio_pkg::SFMIO_IGNORE, "quad refused state");
      host.stop();
    end
    $display("test quad off done");
  endtask
  task automatic t_pause;
    logic [31:0] d;
    host.start();
    host.xfer(1, 8, 1'b1, {`SFMIO_OP_READ, 24'h0}, d);
    host.xfer(1, 24, 1'b1, 32'h00010000, d);
    host.xfer(1, 8, 1'b0, 32'h0, d);
    check(d[7:0], 8'h5A, "byte before pause");
    host.hold(1'b1);
    repeat (12) @(posedge ref_clk);
    host.xfer(1, 4, 1'b0, 32'h0, d);
    check(io_oe, 4'h0, "paused drive");
    host.hold(1'b0);
    repeat (12) @(posedge ref_clk);
    host.xfer(1, 8, 1'b0, 32'h0, d);
    check(d[7:0], 8'h5B, "byte after pause");
    host.stop();
    $display("test pause done");
  endtask
  task automatic t_writes;
    logic [7:0] ops[5] = '{`SFMIO_OP_PROG, `SFMIO_OP_SERASE,
      `SFMIO_OP_BERASE, `SFMIO_OP_CERASE, `SFMIO_OP_WRSR};
    int e0;
    for (int i = 0; i < 5; i++)
    begin
      e0 = exec_cnt;
      wr(ops[i], 8 * (i + 1));
      check(exec_cnt - e0, 1, "write executed");
      check(last_op, ops[i], "write opcode");
    end
    e0 = exec_cnt;
    wr(`SFMIO_OP_CERASE, 9);
    wr(`SFMIO_OP_PROG, 39);
    check(exec_cnt - e0, 0, "odd count write");
    $display("test writes done");
  endtask
  task automatic t_guard;
    int e0;
    int w0;
    @(posedge ref_clk);
    supply_low <= 1'b1;
    e0 = exec_cnt;
    wr(`SFMIO_OP_CERASE, 8);
    check(exec_cnt - e0, 0, "low supply write");
    @(posedge ref_clk);
    supply_low <= 1'b0;
    deep <= 1'b1;
    w0 = wake_cnt;
    wr(`SFMIO_OP_CERASE, 8);
    check(exec_cnt - e0, 0, "sleep write");
    wr(`SFMIO_OP_WAKE, 8);
    check(wake_cnt - w0, 1, "wake command");
    @(posedge ref_clk);
    deep <= 1'b0;
    $display("test guards done");
  endtask
  initial
  begin
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    rel_cyc = cyc;
    repeat (8) @(posedge ref_clk);
    t_powerup();
    t_reads();
    t_quad_off();
    t_pause();
    t_writes();
    t_guard();
    summarize();
  end
  initial
  begin
    #200000;
    $display("MISMATCH %0t: watchdog expired", $time);
    mismatches++;
    summarize();
  end
endmodule
